/* design/cod_clock_output.sv */
`timescale 1ns/1ns
module cod_clock_output (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [cod_pkg::ADDR_W-1:0] busAddr,
   input wire logic [cod_pkg::DATA_W-1:0] busWrData,
   input wire logic busWrite,
   input wire logic busBitWrite,
   input wire logic [2:0] busBitSel,
   input wire logic busRead,
   output logic [cod_pkg::DATA_W-1:0] busRdData_r,
   input wire logic highSpeedTick,
   input wire logic subsystemClock,
   input wire logic clockOutputPinIn,
   output logic clockOutputPinOut_r,
   output logic clockOutputPinOe_r,
   output logic clockRunning_r
);
   import cod_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Register storage

   logic [DATA_W-1:0] clockOutputSelect_r;
   logic [DATA_W-1:0] clockOutputSelect_nxt;
   logic [DATA_W-1:0] port14Direction_r;
   logic [DATA_W-1:0] port14Direction_nxt;
   logic [DATA_W-1:0] port14Latch_r;
   logic [DATA_W-1:0] port14Latch_nxt;
   logic [DATA_W-1:0] busRdData_nxt;

   cod_state_t state_r;
   cod_state_t state_nxt;

   logic hitSelect;
   logic hitDirection;
   logic hitLatch;
   logic anyWrite;
   logic [DATA_W-1:0] bitMask;
   logic bitValue;

   logic clockPinEnable;
   logic [SEL_W-1:0] sourceSelect;
   logic sharedPinDirectionBit;
   logic sharedPinLatch;

   logic srcLevel;
   logic dividerRun;
   logic gateOpen;
   logic gatedClock;
   logic pinOut_nxt;
   logic pinOe_nxt;
   logic [DATA_W-1:0] latchReadback;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign hitSelect = busAddr == CLOCK_OUTPUT_SELECT_ADDR;
   assign hitDirection = busAddr == PORT14_DIRECTION_ADDR;
   assign hitLatch = busAddr == PORT14_LATCH_ADDR;
   assign anyWrite = busWrite | busBitWrite;

   // Bit write touches one bit, value taken from data bit 0
   assign bitMask = busBitWrite ? (8'h01 << busBitSel) : 8'hFF;
   assign bitValue = busWrData[0];

   function automatic logic [DATA_W-1:0] merge_write(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] mask,
      input logic [DATA_W-1:0] full,
      input logic bitWr,
      input logic bitVal
   );
      logic [DATA_W-1:0] src;
      src = bitWr ? {DATA_W{bitVal}} : full;
      merge_write = (old & ~mask) | (src & mask);
   endfunction

   // Bits 7 to 5 are hardwired low whatever is written
   assign clockOutputSelect_nxt = (anyWrite && hitSelect) ?
      (merge_write(clockOutputSelect_r, bitMask, busWrData, busBitWrite,
                   bitValue) & 8'h1F) :
      clockOutputSelect_r; // [RULE_13] [RULE_14]

   assign port14Direction_nxt = (anyWrite && hitDirection) ?
      merge_write(port14Direction_r, bitMask, busWrData, busBitWrite,
                  bitValue) :
      port14Direction_r;

   assign port14Latch_nxt = (anyWrite && hitLatch) ?
      merge_write(port14Latch_r, bitMask, busWrData, busBitWrite,
                  bitValue) :
      port14Latch_r;

   // Input pin reads the pad level, output pin reads its latch
   assign latchReadback = sharedPinDirectionBit ?
      {port14Latch_r[DATA_W-1:1], clockOutputPinIn} : port14Latch_r;

   assign busRdData_nxt = !busRead ? READ_IDLE :
                          hitSelect ? clockOutputSelect_r :
                          hitDirection ? port14Direction_r :
                          hitLatch ? latchReadback :
                          READ_IDLE;

   ////////////////////////////////////////////////////////////////////////
   // Fields

   assign clockPinEnable = clockOutputSelect_r[ENABLE_BIT]; // [RULE_14]
   assign sourceSelect = clockOutputSelect_r[SEL_LSB +: SEL_W];
   assign sharedPinDirectionBit = port14Direction_r[SHARED_PIN_BIT];
   assign sharedPinLatch = port14Latch_r[SHARED_PIN_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Divider

   // Keeps running through a drain so the high phase can finish
   assign dividerRun = clockPinEnable |
                       (state_r != COD_OFF); // [RULE_01] [RULE_02]

   cod_divider #(
      .CNT_W(DIV_W)
   ) u_divider (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .run(dividerRun),
      .highSpeedTick(highSpeedTick),
      .subsystemClock(subsystemClock),
      .sourceSelect(sourceSelect),
      .srcLevel_r(srcLevel)
   );

   ////////////////////////////////////////////////////////////////////////
   // Glitch-free gate

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         COD_OFF: begin
            if (clockPinEnable) begin
               state_nxt = COD_ARM;
            end
         end
         COD_ARM: begin
            if (!clockPinEnable) begin
               state_nxt = COD_OFF;
            end else if (!srcLevel) begin
               state_nxt = COD_ON; // [RULE_09]
            end
         end
         COD_ON: begin
            if (!clockPinEnable) begin
               state_nxt = srcLevel ? COD_DRAIN : COD_OFF; // [RULE_10]
            end
         end
         COD_DRAIN: begin
            if (clockPinEnable) begin
               state_nxt = COD_ON;
            end else if (!srcLevel) begin
               state_nxt = COD_OFF; // [RULE_10]
            end
         end
      endcase
   end

   // Gate opens only in a low phase and closes only in one
   assign gateOpen = (state_r == COD_ON) | (state_r == COD_DRAIN); // [RULE_08]
   assign gatedClock = gateOpen & srcLevel; // [RULE_01] [RULE_02]

   // Latch is ORed in, so a set latch masks the clock
   assign pinOut_nxt = !sharedPinDirectionBit &
                       (sharedPinLatch | gatedClock);
   assign pinOe_nxt = !sharedPinDirectionBit;

   ////////////////////////////////////////////////////////////////////////
   // Flops

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         clockOutputSelect_r <= CLOCK_OUTPUT_SELECT_RST; // [RULE_05]
         port14Direction_r <= PORT14_DIRECTION_RST; // [RULE_12]
         port14Latch_r <= PORT14_LATCH_RST;
         busRdData_r <= READ_IDLE;
         state_r <= COD_OFF;
      end else begin
         clockOutputSelect_r <= clockOutputSelect_nxt;
         port14Direction_r <= port14Direction_nxt;
         port14Latch_r <= port14Latch_nxt;
         busRdData_r <= busRdData_nxt;
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         clockOutputPinOut_r <= 1'b0;
         clockOutputPinOe_r <= 1'b0;
         clockRunning_r <= 1'b0;
      end else begin
         clockOutputPinOut_r <= pinOut_nxt;
         clockOutputPinOe_r <= pinOe_nxt;
         clockRunning_r <= gateOpen;
      end
   end

endmodule

/* design/cod_pkg.sv */
// Summary of operation
// [RULE_01] With the enable bit at 0 the divider is stopped and the pin is held low.
// [RULE_02] With the enable bit at 1 the divider runs and the selected clock reaches the pin.
// [RULE_03] Select codes 0 to 7 give the fast clock over 2 to the code, code 8 the subsystem clock, other codes are not allowed.
// [RULE_04] Software keeps the chosen output frequency at or below 10 MHz.
// [RULE_05] Reset clears the clock output select register to zero, so the output is off and the undivided clock is chosen.
// [RULE_06] Software writes the select code into bits 3 to 0 while the output is still off.
// [RULE_07] Software then sets bit 4 to start the output.
// [RULE_08] Turning the output on or off never puts a shortened pulse on the pin.
// [RULE_09] After enable the pin starts following the clock only in a low phase.
// [RULE_10] After disable the pin is held low only once the running high phase has ended.
// [RULE_11] Software clears the shared pin direction bit and its latch to use the pin as clock output.
// [RULE_12] Reset sets every bit of the port 14 direction register to 1.
// [RULE_13] The clock output select register takes single-bit writes as well as byte writes.
// [RULE_14] Enable sits at bit 4, the select field at bits 3 to 0, bits 7 to 5 read 0.
// [RULE_15] The divider counter is cleared while the output is off.
package cod_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int SEL_W = 4;
   localparam int DIV_W = 8;

   localparam logic [ADDR_W-1:0] CLOCK_OUTPUT_SELECT_ADDR = 16'hFF40;
   localparam logic [ADDR_W-1:0] PORT14_DIRECTION_ADDR = 16'hFF2E;
   localparam logic [ADDR_W-1:0] PORT14_LATCH_ADDR = 16'hFF0E;

   localparam int ENABLE_BIT = 4;
   localparam int SEL_LSB = 0;
   localparam int SHARED_PIN_BIT = 0;

   localparam logic [DATA_W-1:0] CLOCK_OUTPUT_SELECT_RST = 8'h00;
   localparam logic [DATA_W-1:0] PORT14_DIRECTION_RST = 8'hFF;
   localparam logic [DATA_W-1:0] PORT14_LATCH_RST = 8'h00;
   localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

   localparam logic [SEL_W-1:0] SEL_DIV_MAX = 4'h7;
   localparam logic [SEL_W-1:0] SEL_SUBSYSTEM = 4'h8;

   typedef enum logic [1:0] {
      COD_OFF = 2'b00,
      COD_ARM = 2'b01,
      COD_ON = 2'b10,
      COD_DRAIN = 2'b11
   } cod_state_t;

endpackage

/* design/cod_divider.sv */
`timescale 1ns/1ns
module cod_divider #(
   parameter int CNT_W = cod_pkg::DIV_W
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic run,
   input wire logic highSpeedTick,
   input wire logic subsystemClock,
   input wire logic [cod_pkg::SEL_W-1:0] sourceSelect,
   output logic srcLevel_r
);
   import cod_pkg::*;

   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic [CNT_W-1:0] countInc;
   logic srcLevel_nxt;
   logic selIsDiv;
   logic selIsSub;

   // Each tick is one edge of the fast clock, so bit n is fx over 2^n
   assign countInc = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
   assign count_nxt = !run ? '0 :
                      (highSpeedTick ? countInc : count_r); // [RULE_15]

   assign selIsDiv = sourceSelect <= SEL_DIV_MAX;
   assign selIsSub = sourceSelect == SEL_SUBSYSTEM;
   // Prohibited codes give a flat low source rather than garbage
   assign srcLevel_nxt = selIsDiv ? count_nxt[sourceSelect[2:0]] :
                         (selIsSub & subsystemClock); // [RULE_03]

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         count_r <= '0;
         srcLevel_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         srcLevel_r <= srcLevel_nxt;
      end
   end

endmodule

/* tb/cod_clock_output_monitor.sv */
`timescale 1ns/1ns
module cod_clock_output_monitor (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [cod_pkg::ADDR_W-1:0] busAddr,
   input wire logic [cod_pkg::DATA_W-1:0] busWrData,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic [cod_pkg::DATA_W-1:0] busRdData_r,
   input wire logic clockOutputPinOut_r,
   input wire logic clockOutputPinOe_r,
   input wire logic clockRunning_r
);
   import cod_pkg::*;
   // Longest high phase is code 7 at the bench fast-clock rate
   localparam int DRAIN_MAX = 700;
   logic selWr;
   assign selWr = busWrite && busAddr == CLOCK_OUTPUT_SELECT_ADDR;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////
   a_reset_clear: assert property (
      $past(!nrst) |-> !clockRunning_r && !clockOutputPinOe_r)
      else $error("outputs not cleared by reset");
   a_top_zero: assert property (
      $past(busRead && busAddr == CLOCK_OUTPUT_SELECT_ADDR)
      |-> busRdData_r[7:5] == 3'h0) else $error("select bits 7:5 not zero");
   a_oe_hides: assert property (
      !clockOutputPinOe_r |-> !clockOutputPinOut_r)
      else $error("pin driven high while released");
   a_idle_low: assert property (
      !clockRunning_r [*3] |-> !clockOutputPinOut_r)
      else $error("pin not low while output off");
   a_full_high: assert property (
      $fell(clockOutputPinOut_r) |-> $past(clockOutputPinOut_r, 2))
      else $error("short high pulse on pin");
   a_full_low: assert property (
      $rose(clockOutputPinOut_r) |-> !$past(clockOutputPinOut_r, 2))
      else $error("short low phase on pin");
   a_en_starts: assert property (
      selWr && busWrData[4] && !busWrData[3] && !clockRunning_r
      |-> ##[1:4] clockRunning_r) else $error("output did not start");
   a_dis_stops: assert property (
      selWr && !busWrData[4] && clockRunning_r
      |-> ##[1:DRAIN_MAX] !clockRunning_r) else $error("output did not stop");
endmodule

/* tb/cod_far_side.sv */
`timescale 1ns/1ns
module cod_far_side (
   input wire logic ref_clk,
   input wire logic pinOut,
   input wire logic pinOe,
   output logic tick,
   output logic subClk,
   output logic pinIn
);
   logic [2:0] tickCnt_r = 3'h0;
   logic [4:0] subCnt_r = 5'h00;
   logic lastOut_r = 1'b0;
   initial begin
      tick = 1'b0;
      subClk = 1'b0;
      pinIn = 1'b0;
   end
   // Fast clock at 10 MHz keeps the undivided output at its limit
   always @(posedge ref_clk) begin
      tickCnt_r <= (tickCnt_r == 3'h4) ? 3'h0 : tickCnt_r + 3'h1;
      tick <= tickCnt_r == 3'h3;
      subCnt_r <= (subCnt_r == 5'h13) ? 5'h00 : subCnt_r + 5'h01;
      subClk <= (subCnt_r == 5'h13) ? !subClk : subClk;
      // Released pad settles to the inverse of the last driven level
      lastOut_r <= (pinOe === 1'b1) ? pinOut : lastOut_r;
      pinIn <= (pinOe === 1'b1) ? pinOut : !lastOut_r;
   end
endmodule

/* tb/tb_cod_clock_output.sv */
`timescale 1ns/1ns
module tb_cod_clock_output;
   import cod_pkg::*;
   logic ref_clk = 1'b0, nrst = 1'b0, busWrite = 1'b0, busBitWrite = 1'b0;
   logic busRead = 1'b0, pinOut, pinOe, running, tick, subClk, pinIn;
   logic [ADDR_W-1:0] busAddr = 16'h0000;
   logic [DATA_W-1:0] busWrData = 8'h00, rdData, w;
   logic [2:0] busBitSel = 3'h0;
   logic [15:0] t0, t1;
   logic hi;
   int miscompares = 0, total_checks = 0, cycles = 0;
   int seed = 32'h9429FA63;
   always #5 ref_clk = !ref_clk;
   always @(posedge ref_clk) cycles <= cycles + 1;
   always @(posedge ref_clk) if (cycles == 40000) begin
      miscompares++;
      end_sim;
   end
   cod_clock_output dut (.ref_clk(ref_clk), .nrst(nrst), .busAddr(busAddr),
      .busWrData(busWrData), .busWrite(busWrite), .busBitWrite(busBitWrite),
      .busBitSel(busBitSel), .busRead(busRead), .busRdData_r(rdData),
      .highSpeedTick(tick), .subsystemClock(subClk), .clockOutputPinIn(pinIn),
      .clockOutputPinOut_r(pinOut), .clockOutputPinOe_r(pinOe),
      .clockRunning_r(running));
   cod_far_side far (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe),
      .tick(tick), .subClk(subClk), .pinIn(pinIn));
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d, input logic bitWr);
      @(posedge ref_clk);
      busAddr <= a;
      busWrData <= d;
      busBitSel <= d[6:4];
      busWrite <= !bitWr;
      busBitWrite <= bitWr;
      @(posedge ref_clk);
      busWrite <= 1'b0;
      busBitWrite <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      busAddr <= a;
      busRead <= 1'b1;
      @(posedge ref_clk);
      busRead <= 1'b0;
      #1 chk({8'h00, rdData}, {8'h00, e});
   endtask
   // Bounded waits: a stuck pin must not hang the run
   task rise(output logic [15:0] t);
      for (int n = 0; n < 3000 && pinOut !== 1'b0; n++) @(posedge ref_clk);
      for (int n = 0; n < 3000 && pinOut !== 1'b1; n++) @(posedge ref_clk);
      t = cycles[15:0];
   endtask
   task off_wait;
      for (int n = 0; n < 800 && running !== 1'b0; n++) @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
      chk({15'h0, running}, 16'h0000);
      chk({15'h0, pinOut}, 16'h0000);
   endtask
   task chk_rst;
      rd(CLOCK_OUTPUT_SELECT_ADDR, 8'h00);
      rd(PORT14_DIRECTION_ADDR, 8'hFF);
      rd(16'hFF41, 8'h00);
      rd(PORT14_LATCH_ADDR, {7'h00, pinIn});
      $display("test reset done");
   endtask
   function logic [15:0] per(input logic [3:0] c);
      per = (c == SEL_SUBSYSTEM) ? 16'h0028 : 16'h000A << c;
   endfunction
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      chk_rst;
      for (int i = 0; i < 4; i++) begin
         w = $random(seed);
         wr(16'hFF3F, w, 1'b0);
         rd(16'hFF3F, 8'h00);
         wr(CLOCK_OUTPUT_SELECT_ADDR, w & 8'hE7, 1'b0);
         rd(CLOCK_OUTPUT_SELECT_ADDR, w & 8'h07);
      end
      wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h41, 1'b1);
      rd(CLOCK_OUTPUT_SELECT_ADDR, (w & 8'h07) | 8'h10);
      wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h40, 1'b1);
      rd(CLOCK_OUTPUT_SELECT_ADDR, w & 8'h07);
      off_wait;
      wr(PORT14_DIRECTION_ADDR, 8'h00, 1'b1);
      wr(PORT14_LATCH_ADDR, 8'h00, 1'b1);
      rd(PORT14_DIRECTION_ADDR, 8'hFE);
      rd(PORT14_LATCH_ADDR, 8'h00);
      chk({15'h0, pinOe}, 16'h0001);
      $display("test registers done");
      for (int c = 0; c < 9; c++) begin
         wr(CLOCK_OUTPUT_SELECT_ADDR, 8'(c), 1'b0);
         wr(CLOCK_OUTPUT_SELECT_ADDR, 8'(c) | 8'h10, 1'b0);
         rise(t0);
         rise(t1);
         chk(t1 - t0, per(4'(c)));
         wr(CLOCK_OUTPUT_SELECT_ADDR, 8'(c), 1'b0);
         off_wait;
      end
      // Prohibited code must leave the pin flat low
      wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h09, 1'b0);
      wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h19, 1'b0);
      hi = 1'b0;
      repeat (100) begin
         @(posedge ref_clk);
         hi = hi | pinOut;
      end
      chk({15'h0, hi}, 16'h0000);
      wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h09, 1'b0);
      off_wait;
      $display("test divider done");
      wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h02, 1'b0);
      wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h12, 1'b0);
      repeat (50) @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      chk_rst;
      chk({15'h0, pinOe}, 16'h0000);
      $display("test midreset done");
      end_sim;
   end
endmodule
bind cod_clock_output cod_clock_output_monitor mon (.ref_clk(ref_clk),
   .nrst(nrst), .busAddr(busAddr), .busWrData(busWrData),
   .busWrite(busWrite), .busRead(busRead), .busRdData_r(busRdData_r),
   .clockOutputPinOut_r(clockOutputPinOut_r),
   .clockOutputPinOe_r(clockOutputPinOe_r), .clockRunning_r(clockRunning_r));
